// *** design/llcps_sequencer.sv ***
// Fault, gate-pattern and start-up sequencer for boost and half-bridge stages
// What this block does
// - Fast overcurrent kills both gates combinationally
// - Eight consecutive slow-trip cycles shut half-bridge down
// - High and low drives never overlap, equal on-times
// - Half-bridge pattern symmetrical at 50% duty
// - Separate dead-time generators serve boost, high and low drives
// - Dead time set by max-frequency program input
// - Supply ready starts boost, half-bridge stays off
// - Boost feedback above start level enables soft start
// - Max-frequency condition blanks high and low gates whole clock cycles, boost gate not blanked
// - Boost feedback below stop level shuts half-bridge
// - Every fault restart goes through fresh soft start
`timescale 1ns/1ns
`include "llcps_defs.svh"
module llcps_sequencer #(
  parameter int HALF_PERIOD = `LLCPS_HALF_PERIOD,
  parameter int SOFT_START_CYCLES = `LLCPS_SOFT_START_CYCLES,
  parameter int DT_W = `LLCPS_DT_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic supply_ready_in,
  input wire logic fast_trip_in,
  input wire logic slow_trip_in,
  input wire logic llc_start_level_in,
  input wire logic llc_stop_level_n_in,
  input wire logic max_freq_limit_in,
  input wire logic [DT_W-1:0] max_freq_program_input_in,
  input wire logic boost_req_in,
  output logic boost_gate_out,
  output logic high_side_gate_drive_out,
  output logic low_side_gate_drive_out,
  output logic soft_start_out,
  output logic halfbridge_enable_out,
  output logic overcurrent_fault_out
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (HALF_PERIOD < 2 || HALF_PERIOD > 255) begin
      $error("HALF_PERIOD out of range");
    end
    if (SOFT_START_CYCLES < 1 || SOFT_START_CYCLES > 255) begin
      $error("SOFT_START_CYCLES out of range");
    end
    // Top dead-time setting may leave a zero on-time, never an overlap
    if (HALF_PERIOD < (1 << DT_W)) begin
      $error("Dead time longer than the half period");
    end
  end

  localparam logic [7:0] HALF_LAST = 8'(HALF_PERIOD - 1);
  localparam logic [7:0] SS_LAST = 8'(SOFT_START_CYCLES - 1);

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  llcps_pkg::llcps_state_t state_q;
  llcps_pkg::llcps_state_t state_d;
  logic [3:0] slow_cnt_q;
  logic [3:0] slow_cnt_d;
  logic [7:0] ss_cnt_q;
  logic [7:0] ss_cnt_d;
  logic ocp_q;
  logic ocp_d;
  logic slow_trip;
  logic hb_fault;

  // Slow trip counter clears on any quiet cycle
  always_comb begin
    slow_cnt_d = 4'h0;
    if (slow_trip_in && (state_q == llcps_pkg::LLCPS_SOFT_START ||
        state_q == llcps_pkg::LLCPS_RUN)) begin
      slow_cnt_d = (slow_cnt_q == `LLCPS_SLOW_TRIP_CYCLES) ? slow_cnt_q : slow_cnt_q + 4'h1;
    end
  end
  assign slow_trip = (slow_cnt_d == `LLCPS_SLOW_TRIP_CYCLES);

  assign hb_fault = fast_trip_in | slow_trip | !llc_stop_level_n_in;

  always_comb begin
    state_d = state_q;
    ss_cnt_d = ss_cnt_q;
    ocp_d = ocp_q;
    case (state_q)
      llcps_pkg::LLCPS_OFF: begin
        if (supply_ready_in) begin
          state_d = llcps_pkg::LLCPS_BOOST_ONLY;
        end
      end
      llcps_pkg::LLCPS_BOOST_ONLY: begin
        ss_cnt_d = 8'h00;
        if (!supply_ready_in) begin
          state_d = llcps_pkg::LLCPS_OFF;
        end else if (llc_start_level_in && llc_stop_level_n_in) begin
          state_d = llcps_pkg::LLCPS_SOFT_START;
          ocp_d = 1'b0;
        end
      end
      llcps_pkg::LLCPS_SOFT_START, llcps_pkg::LLCPS_RUN: begin
        if (!supply_ready_in) begin
          state_d = llcps_pkg::LLCPS_OFF;
        end else if (hb_fault) begin
          state_d = llcps_pkg::LLCPS_FAULT;
          ocp_d = fast_trip_in | slow_trip;
        end else if (state_q == llcps_pkg::LLCPS_SOFT_START) begin
          if (ss_cnt_q == SS_LAST) begin
            state_d = llcps_pkg::LLCPS_RUN;
          end else begin
            ss_cnt_d = ss_cnt_q + 8'h01;
          end
        end
      end
      llcps_pkg::LLCPS_FAULT: begin
        // Back through boost-only so the next start is a fresh soft start
        if (!supply_ready_in) begin
          state_d = llcps_pkg::LLCPS_OFF;
        end else if (!fast_trip_in && !slow_trip_in) begin
          state_d = llcps_pkg::LLCPS_BOOST_ONLY;
        end
      end
      default: begin
        state_d = llcps_pkg::LLCPS_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state_q <= llcps_pkg::LLCPS_OFF;
      slow_cnt_q <= 4'h0;
      ss_cnt_q <= 8'h00;
      ocp_q <= 1'b0;
    end else begin
      state_q <= state_d;
      slow_cnt_q <= slow_cnt_d;
      ss_cnt_q <= ss_cnt_d;
      ocp_q <= ocp_d;
    end
  end

  // ----------------------------------------------------------------
  // Half-bridge pattern
  // ----------------------------------------------------------------
  logic [7:0] phase_cnt_q;
  logic [7:0] phase_cnt_d;
  logic phase_q;
  logic phase_d;
  logic hb_run;
  logic blank_q;
  logic blank_d;

  assign hb_run = (state_q == llcps_pkg::LLCPS_SOFT_START) ||
                  (state_q == llcps_pkg::LLCPS_RUN);

  // Equal half periods give 50% duty on each side
  always_comb begin
    phase_cnt_d = 8'h00;
    phase_d = 1'b0;
    if (hb_run) begin
      phase_d = phase_q;
      if (phase_cnt_q == HALF_LAST) begin
        phase_cnt_d = 8'h00;
        phase_d = !phase_q;
      end else begin
        phase_cnt_d = phase_cnt_q + 8'h01;
      end
    end
    blank_d = max_freq_limit_in;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      phase_cnt_q <= 8'h00;
      phase_q <= 1'b0;
      blank_q <= 1'b0;
    end else begin
      phase_cnt_q <= phase_cnt_d;
      phase_q <= phase_d;
      blank_q <= blank_d;
    end
  end

  logic hb_enable;
  logic high_req;
  logic low_req;
  logic high_dt;
  logic low_dt;
  logic boost_dt;
  logic [2:0] dt_req;
  logic [2:0] dt_drive;

  assign hb_enable = hb_run && !blank_q && !ocp_q;
  assign high_req = hb_enable && phase_q;
  assign low_req = hb_enable && !phase_q;
  assign dt_req = {boost_req_in && (state_q != llcps_pkg::LLCPS_OFF), high_req, low_req};

  // Each output rising edge is delayed by the same programmed dead time
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_dt
      llcps_dead_time #(
        .DT_W(DT_W)
      ) u_dt (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .req_in(dt_req[gi]),
        .dead_time_in(max_freq_program_input_in),
        .drive_out(dt_drive[gi])
      );
    end
  endgenerate

  assign low_dt = dt_drive[0];
  assign high_dt = dt_drive[1];
  assign boost_dt = dt_drive[2];

  // Fast trip bypasses every flop
  assign high_side_gate_drive_out = high_dt && !low_dt && !fast_trip_in;
  assign low_side_gate_drive_out = low_dt && !high_dt && !fast_trip_in;
  assign boost_gate_out = boost_dt;
  assign soft_start_out = (state_q == llcps_pkg::LLCPS_SOFT_START);
  assign halfbridge_enable_out = hb_run;
  assign overcurrent_fault_out = ocp_q;
endmodule // llcps_sequencer

// *** design/llcps_defs.svh ***
// Timing counts and widths for the half-bridge protection sequencer
`ifndef LLCPS_DEFS_SVH
`define LLCPS_DEFS_SVH

// Consecutive slow overcurrent cycles before shutdown
`define LLCPS_SLOW_TRIP_CYCLES 4'h8
// Half switching period in clock cycles (default)
`define LLCPS_HALF_PERIOD 8'h10
// Dead-time setting width
`define LLCPS_DT_WIDTH 4
// Soft-start length in clock cycles (default)
`define LLCPS_SOFT_START_CYCLES 8'h40

`endif

// *** design/llcps_pkg.sv ***
// Types for the half-bridge protection sequencer
package llcps_pkg;
  typedef enum logic [2:0] {
    LLCPS_OFF,
    LLCPS_BOOST_ONLY,
    LLCPS_SOFT_START,
    LLCPS_RUN,
    LLCPS_FAULT
  } llcps_state_t;
endpackage

// *** design/llcps_dead_time.sv ***
// Per-drive dead-time generator: delays the rising edge of one drive request
`timescale 1ns/1ns
`include "llcps_defs.svh"
module llcps_dead_time #(
  parameter int DT_W = `LLCPS_DT_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic req_in,
  input wire logic [DT_W-1:0] dead_time_in,
  output logic drive_out
);
  logic [DT_W-1:0] cnt_q;
  logic [DT_W-1:0] cnt_d;
  logic drive_q;
  logic drive_d;

  always_comb begin
    cnt_d = cnt_q;
    drive_d = 1'b0;
    if (!req_in) begin
      cnt_d = '0;
    end else if (cnt_q >= dead_time_in) begin
      drive_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      drive_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      drive_q <= drive_d;
    end
  end

  assign drive_out = drive_q & req_in;
endmodule // llcps_dead_time

// *** tb/llcps_properties.sv ***
// Concurrent checks on the sequencer ports
`timescale 1ns/1ns
module llcps_properties #(
  parameter int HALF_PERIOD = 16,
  parameter int SOFT_START_CYCLES = 64,
  parameter int DT_W = 4
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic supply_ready_in,
  input wire logic fast_trip_in,
  input wire logic slow_trip_in,
  input wire logic llc_start_level_in,
  input wire logic llc_stop_level_n_in,
  input wire logic max_freq_limit_in,
  input wire logic [DT_W-1:0] max_freq_program_input_in,
  input wire logic boost_req_in,
  input wire logic boost_gate_out,
  input wire logic high_side_gate_drive_out,
  input wire logic low_side_gate_drive_out,
  input wire logic soft_start_out,
  input wire logic halfbridge_enable_out,
  input wire logic overcurrent_fault_out
);
  wire g = high_side_gate_drive_out | low_side_gate_drive_out;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_fast; fast_trip_in |-> !g; endproperty
  a_fast: assert property (p_fast) else $error("gate on during fast trip");
  property p_ovl; !(high_side_gate_drive_out && low_side_gate_drive_out); endproperty
  a_ovl: assert property (p_ovl) else $error("gates overlap");
  property p_slow;
    (slow_trip_in && halfbridge_enable_out)[*8] |=> !halfbridge_enable_out && overcurrent_fault_out;
  endproperty
  a_slow: assert property (p_slow) else $error("no slow trip shutdown");
  property p_off; !halfbridge_enable_out || overcurrent_fault_out |-> !g; endproperty
  a_off: assert property (p_off) else $error("gate on while stage off");
  property p_start;
    $rose(halfbridge_enable_out) |-> soft_start_out && $past(llc_start_level_in);
  endproperty
  a_start: assert property (p_start) else $error("enable without soft start");
  property p_stop; halfbridge_enable_out && !llc_stop_level_n_in |=> !halfbridge_enable_out;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop level shutdown");
  property p_blank; max_freq_limit_in |=> !g; endproperty
  a_blank: assert property (p_blank) else $error("gate on at frequency limit");
  property p_gap; $rose(high_side_gate_drive_out) |-> $past(!low_side_gate_drive_out);
  endproperty
  a_gap: assert property (p_gap) else $error("no dead time gap");
  property p_boost; boost_gate_out |-> boost_req_in && $past(boost_req_in); endproperty
  a_boost: assert property (p_boost) else $error("boost gate without held request");
  c_boost: cover property ($rose(boost_gate_out));
  c_trip: cover property ($rose(overcurrent_fault_out));
  c_en: cover property ($rose(halfbridge_enable_out));
  c_hs: cover property ($rose(high_side_gate_drive_out));
endmodule // llcps_properties

// *** tb/llcps_fet_model.sv ***
// Power stage model: measures each gate's last on-time
`timescale 1ns/1ns
module llcps_fet_model (
  input wire logic sys_clk_in,
  input wire logic hs_gate_in,
  input wire logic ls_gate_in,
  output logic [3:0] hs_on_out,
  output logic [3:0] ls_on_out
);
  logic [3:0] hs_q;
  logic [3:0] ls_q;
  always_ff @(posedge sys_clk_in) begin
    hs_q <= hs_gate_in ? hs_q + 4'h1 : 4'h0;
    ls_q <= ls_gate_in ? ls_q + 4'h1 : 4'h0;
    if (!hs_gate_in && hs_q != 4'h0) hs_on_out <= hs_q;
    if (!ls_gate_in && ls_q != 4'h0) ls_on_out <= ls_q;
  end
endmodule // llcps_fet_model

// *** tb/llcps_sequencer_tb.sv ***
// Self-checking bench for the protection sequencer
`timescale 1ns/1ns
module llcps_sequencer_tb;
  logic clk = 1'h0, rst_n = 1'h0, sup = 1'h0, fast = 1'h0, slow = 1'h0, start = 1'h0;
  logic stop_n = 1'h1, lim = 1'h0, breq = 1'h0, look = 1'h0, hold = 1'h0;
  logic [3:0] dt = 4'h3, hs_on, ls_on;
  logic boost, hs, ls, ss, en, oc;
  logic [23:0] exp_q[$];
  logic [23:0] ent;
  logic [31:0] rng = 32'h0000_0060;
  int n_fail = 0, num_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  llcps_sequencer #(.HALF_PERIOD(16), .SOFT_START_CYCLES(64), .DT_W(4)) i_dut (
    .sys_clk_in(clk), .rst_n_in(rst_n), .supply_ready_in(sup), .fast_trip_in(fast),
    .slow_trip_in(slow), .llc_start_level_in(start), .llc_stop_level_n_in(stop_n),
    .max_freq_limit_in(lim), .max_freq_program_input_in(dt), .boost_req_in(breq),
    .boost_gate_out(boost), .high_side_gate_drive_out(hs), .low_side_gate_drive_out(ls),
    .soft_start_out(ss), .halfbridge_enable_out(en), .overcurrent_fault_out(oc));
  llcps_fet_model i_fet (.sys_clk_in(clk), .hs_gate_in(hs), .ls_gate_in(ls),
    .hs_on_out(hs_on), .ls_on_out(ls_on));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic run(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic note(input logic [11:0] m, input logic [11:0] v);
    exp_q.push_back({m, v});
    look <= 1'h1;
    @(posedge clk);
    look <= 1'h0;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] want);
    num_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[ERR] boost_en_ss_oc_on_times exp %h seen %h", want, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Outputs settle by the falling edge
  always @(negedge clk) begin
    if (look) begin
      ent = exp_q.pop_front();
      chk({boost, en, ss, oc, hs_on, ls_on} & ent[23:12], ent[11:0]);
    end
  end
  always @(posedge clk) begin
    rng <= xs(rng);
    // Forced high for a known boost rise, random otherwise
    breq <= rng[0] | hold;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      print_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    run(5);
    rst_n <= 1'h1;
    note(12'h700, 12'h000);
    hold <= 1'h1;
    run(4);
    note(12'hf00, 12'h000);
    sup <= 1'h1;
    run(6);
    note(12'hf00, 12'h800);
    hold <= 1'h0;
    start <= 1'h1;
    run(3);
    note(12'h700, 12'h600);
    run(64);
    note(12'h700, 12'h400);
    for (int i = 0; i < 3; i++) begin
      dt <= {1'h0, rng[2:0]};
      run(100);
      note(12'h0ff, {4'h0, 4'hf - dt, 4'hf - dt});
    end
    lim <= 1'h1;
    run(40);
    lim <= 1'h0;
    slow <= 1'h1;
    run(7);
    slow <= 1'h0;
    note(12'h700, 12'h400);
    slow <= 1'h1;
    run(8);
    note(12'h700, 12'h100);
    slow <= 1'h0;
    run(5);
    note(12'h700, 12'h600);
    fast <= 1'h1;
    run(2);
    fast <= 1'h0;
    note(12'h700, 12'h100);
    run(5);
    note(12'h700, 12'h600);
    stop_n <= 1'h0;
    run(3);
    note(12'h700, 12'h000);
    stop_n <= 1'h1;
    run(3);
    rst_n <= 1'h0;
    run(2);
    note(12'h700, 12'h000);
    print_verdict();
  end
endmodule // llcps_sequencer_tb
bind llcps_sequencer llcps_properties #(.HALF_PERIOD(HALF_PERIOD),
  .SOFT_START_CYCLES(SOFT_START_CYCLES), .DT_W(DT_W)) i_props (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .supply_ready_in(supply_ready_in),
  .fast_trip_in(fast_trip_in),
  .slow_trip_in(slow_trip_in),
  .llc_start_level_in(llc_start_level_in),
  .llc_stop_level_n_in(llc_stop_level_n_in),
  .max_freq_limit_in(max_freq_limit_in),
  .max_freq_program_input_in(max_freq_program_input_in),
  .boost_req_in(boost_req_in),
  .boost_gate_out(boost_gate_out),
  .high_side_gate_drive_out(high_side_gate_drive_out),
  .low_side_gate_drive_out(low_side_gate_drive_out),
  .soft_start_out(soft_start_out),
  .halfbridge_enable_out(halfbridge_enable_out),
  .overcurrent_fault_out(overcurrent_fault_out));
